// file: core/mrsc_defs.svh
`ifndef MRSC_DEFS_SVH
`define MRSC_DEFS_SVH
// Register byte offsets on the AXI4-Lite bus
`define MRSC_OFF_LVSEL 8'h00
`define MRSC_OFF_FLAGS 8'h04
`define MRSC_OFF_WDCTL 8'h08
`define MRSC_OFF_STATUS 8'h0C
`define MRSC_OFF_MODE 8'h10
// Reset values
`define MRSC_LVSEL_RST 8'h55
`define MRSC_WDCTL_RST 8'h53
// Threshold codes
`define MRSC_LV_2V10 8'h55
`define MRSC_LV_2V55 8'h33
`define MRSC_LV_3V15 8'h99
`define MRSC_LV_3V80 8'hAA
// Watchdog key codes
`define MRSC_WD_KEY_DIS 5'h15
`define MRSC_WD_KEY_EN 5'h0A
// Flag bit positions in reset_source_flags
`define MRSC_BIT_WDERR 0
`define MRSC_BIT_LVERR 1
`define MRSC_BIT_LVRST 2
// Status bit positions
`define MRSC_BIT_EXPIRY 0
`define MRSC_BIT_PDOWN 1
// Times
`define MRSC_POR_DELAY_MS 50
`define MRSC_WDT_DELAY_US 16700
`define MRSC_CLK_HZ 10000000
`define MRSC_SLOW_DIV 312
`define MRSC_KEY_DELAY_SLOW 2
`define MRSC_SETTLE_FAST 16
`define MRSC_SETTLE_XTAL 1024
`define MRSC_SETTLE_SLOW 2
`define MRSC_LV_MIN_CYC 16
`endif

// file: core/mrsc_pkg.sv
package mrsc_pkg;
   typedef enum logic [1:0] {
      MRSC_RUN = 2'b00,
      MRSC_HOLD = 2'b01,
      MRSC_SETTLE = 2'b10
   } mrsc_state_t;
   typedef enum logic [1:0] {
      MRSC_CLK_FAST = 2'b00,
      MRSC_CLK_XTAL = 2'b01,
      MRSC_CLK_SLOW = 2'b10
   } mrsc_clksrc_t;
endpackage : mrsc_pkg

// file: core/mrsc_reset_ctrl.sv
// What this block does
// [R1] All reset sources merge into one reset
// [R2] Power-on clears program counter
// [R3] Power-on sets port registers to ones
// [R4] Power-on holds reset for 50 ms
// [R5] Qualified low voltage resets, sets flag
// [R6] Short low-voltage glitches are ignored
// [R7] Decode four valid threshold codes
// [R8] Bad threshold code resets, sets error
// [R9] Bad threshold restores select to 0x55
// [R10] Brownout reset delayed, select kept
// [R11] Brownout disabled in power-down
// [R12] Low-voltage flag cleared only by software
// [R13] Normal watchdog expiry acts like power-on
// [R14] Normal watchdog reset releases after 16.7 ms
// [R15] Sleep expiry clears only counter, stack
// [R16] Wake waits settle time per clock
// [R17] Bad watchdog key resets, sets error
// [R18] Key 10101 disables, 01010 enables watchdog
// [R19] Bad key reset after slow clock cycles
// [R20] Key error flag cleared only by software
// [R21] Sleep expiry sets both flags; power-on clears
// [R22] Fault requests synchronised to slow clock tick; watchdog expiry is not
//
// Implementation choices: the AXI4-Lite slave port and the placing of the registers.
`include "mrsc_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module mrsc_reset_ctrl
   import mrsc_pkg::*;
#(
   parameter int POR_CYCLES = (`MRSC_POR_DELAY_MS * (`MRSC_CLK_HZ / 1000)),
   parameter int WDT_CYCLES = (`MRSC_WDT_DELAY_US * (`MRSC_CLK_HZ / 1000000)),
   parameter int SLOW_DIV = `MRSC_SLOW_DIV,
   parameter int LV_MIN_CYCLES = `MRSC_LV_MIN_CYC
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic lowvolt_detect,
   input wire logic watchdog_timeout,
   input wire logic sleep_mode,
   input wire logic powerdown_mode,
   output logic core_reset,
   output logic pc_clear,
   output logic port_preset,
   output logic watchdog_enable,
   output logic [2:0] wd_period_sel,
   output logic [7:0] lv_threshold_sel,
   output logic [1:0] lv_level
);
   // Check for a valid threshold code
   function automatic logic lv_code_ok(input logic [7:0] c);
      return (c == `MRSC_LV_2V10) || (c == `MRSC_LV_2V55) ||
             (c == `MRSC_LV_3V15) || (c == `MRSC_LV_3V80);
   endfunction : lv_code_ok

   // Check for a valid watchdog key
   function automatic logic wd_key_ok(input logic [4:0] k);
      return (k == `MRSC_WD_KEY_DIS) || (k == `MRSC_WD_KEY_EN);
   endfunction : wd_key_ok

   logic [7:0] lvsel_q;
   logic [7:0] wdctl_q;
   logic lvrst_flag_q;
   logic lverr_flag_q;
   logic wderr_flag_q;
   logic expiry_flag_q;
   logic pdown_flag_q;
   logic [1:0] clksrc_q;
   logic [31:0] slow_cnt_q;
   logic slow_tick;
   logic [31:0] lv_cnt_q;
   logic lv_qual;
   logic [1:0] lverr_cnt_q;
   logic [1:0] wderr_cnt_q;
   logic [1:0] lvrst_cnt_q;
   logic lv_fire;
   logic lverr_fire;
   logic wderr_fire;
   logic wdt_normal;
   logic wdt_sleep;
   mrsc_state_t state_q;
   logic [31:0] hold_q;
   logic aw_q;
   logic w_q;
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic wr_go;
   logic wr_flags;
   logic flag_wr_lvrst;
   logic flag_wr_lverr;
   logic flag_wr_wderr;

   // Slow oscillator tick, one pulse per slow clock cycle
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         slow_cnt_q <= 32'h0000_0000;
      end else if (slow_cnt_q >= 32'(SLOW_DIV - 1)) begin
         slow_cnt_q <= 32'h0000_0000;
      end else begin
         slow_cnt_q <= slow_cnt_q + 32'h0000_0001;
      end
   end
   assign slow_tick = (slow_cnt_q == 32'h0000_0000);

   // Low-voltage qualification; brownout off in power-down
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         lv_cnt_q <= 32'h0000_0000;
      end else if (!lowvolt_detect || powerdown_mode) begin // R11
         lv_cnt_q <= 32'h0000_0000; // R6
      end else if (lv_cnt_q <= 32'(LV_MIN_CYCLES)) begin
         lv_cnt_q <= lv_cnt_q + 32'h0000_0001;
      end
   end
   assign lv_qual = (lv_cnt_q > 32'(LV_MIN_CYCLES)); // R6

   // Fault delays counted on slow ticks; requests taken on tick edges
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         lvrst_cnt_q <= 2'b00;
         lverr_cnt_q <= 2'b00;
         wderr_cnt_q <= 2'b00;
      end else if (state_q != MRSC_RUN) begin
         lvrst_cnt_q <= 2'b00;
         lverr_cnt_q <= 2'b00;
         wderr_cnt_q <= 2'b00;
      end else if (slow_tick) begin // R22
         lvrst_cnt_q <= lv_qual ? lvrst_cnt_q + 2'b01 : 2'b00; // R10
         lverr_cnt_q <= lv_code_ok(lvsel_q) ? 2'b00 : lverr_cnt_q + 2'b01; // R8
         wderr_cnt_q <= wd_key_ok(wdctl_q[7:3]) ? 2'b00 : wderr_cnt_q + 2'b01; // R19
      end
   end
   assign lv_fire = slow_tick && lv_qual && (lvrst_cnt_q == 2'(`MRSC_KEY_DELAY_SLOW)); // R5
   assign lverr_fire = slow_tick && !lv_code_ok(lvsel_q) &&
                       (lverr_cnt_q == 2'(`MRSC_KEY_DELAY_SLOW)); // R8
   assign wderr_fire = slow_tick && !wd_key_ok(wdctl_q[7:3]) &&
                       (wderr_cnt_q == 2'(`MRSC_KEY_DELAY_SLOW)); // R17
   assign wdt_normal = watchdog_timeout && watchdog_enable && !sleep_mode;
   assign wdt_sleep = watchdog_timeout && watchdog_enable && sleep_mode;

   // Reset sequencer: power-on hold, fault holds, wake settle
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_q <= MRSC_HOLD;
         hold_q <= 32'(POR_CYCLES); // R4
      end else begin
         case (state_q)
            MRSC_RUN: begin
               if (lv_fire || lverr_fire || wderr_fire) begin // R1
                  state_q <= MRSC_HOLD;
                  hold_q <= 32'(POR_CYCLES);
               end else if (wdt_normal) begin // R13
                  state_q <= MRSC_HOLD;
                  hold_q <= 32'(WDT_CYCLES); // R14
               end else if (wdt_sleep) begin // R15
                  state_q <= MRSC_SETTLE;
                  case (clksrc_q) // R16
                     MRSC_CLK_XTAL: hold_q <= 32'(`MRSC_SETTLE_XTAL);
                     MRSC_CLK_SLOW: hold_q <= 32'(`MRSC_SETTLE_SLOW * SLOW_DIV);
                     default: hold_q <= 32'(`MRSC_SETTLE_FAST);
                  endcase
               end
            end
            MRSC_HOLD, MRSC_SETTLE: begin
               if (hold_q <= 32'h0000_0001) begin
                  state_q <= MRSC_RUN;
               end
               hold_q <= hold_q - 32'h0000_0001;
            end
            default: begin
               state_q <= MRSC_HOLD;
               hold_q <= 32'(POR_CYCLES);
            end
         endcase
      end
   end

   // Reset outputs to the core
   assign core_reset = (state_q == MRSC_HOLD); // R1
   assign pc_clear = (state_q != MRSC_RUN); // R2
   assign port_preset = (state_q == MRSC_HOLD); // R3
   assign watchdog_enable = (wdctl_q[7:3] != `MRSC_WD_KEY_DIS); // R18
   assign wd_period_sel = wdctl_q[2:0];
   assign lv_threshold_sel = lvsel_q;

   // Threshold level decode
   always_comb begin
      case (lvsel_q) // R7
         `MRSC_LV_2V55: lv_level = 2'b01;
         `MRSC_LV_3V15: lv_level = 2'b10;
         `MRSC_LV_3V80: lv_level = 2'b11;
         default: lv_level = 2'b00;
      endcase
   end

   // AXI write address and data capture
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         aw_q <= 1'b0;
         w_q <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
      end else if (wr_go) begin
         aw_q <= 1'b0;
         w_q <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
      end
   end
   assign s_axi_awready = !aw_q && !s_axi_bvalid;
   assign s_axi_wready = !w_q && !s_axi_bvalid;
   assign wr_go = aw_q && w_q && !s_axi_bvalid;
   assign wr_flags = wr_go && wstrb_q[0] && (awaddr_q[7:2] == 6'(`MRSC_OFF_FLAGS >> 2));
   assign flag_wr_lvrst = wr_flags && !wdata_q[`MRSC_BIT_LVRST];
   assign flag_wr_lverr = wr_flags && !wdata_q[`MRSC_BIT_LVERR];
   assign flag_wr_wderr = wr_flags && !wdata_q[`MRSC_BIT_WDERR];

   // Write response
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= (awaddr_q[7:2] > 6'(`MRSC_OFF_MODE >> 2)) ? 2'b10 : 2'b00;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Control registers; invalid threshold restores power-on code
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         lvsel_q <= `MRSC_LVSEL_RST;
         wdctl_q <= `MRSC_WDCTL_RST;
         clksrc_q <= MRSC_CLK_FAST;
      end else if (lverr_fire) begin
         lvsel_q <= `MRSC_LVSEL_RST; // R9
      end else if (wr_go && wstrb_q[0]) begin // R10
         case (awaddr_q[7:2])
            6'(`MRSC_OFF_LVSEL >> 2): lvsel_q <= wdata_q[7:0];
            6'(`MRSC_OFF_WDCTL >> 2): wdctl_q <= wdata_q[7:0];
            6'(`MRSC_OFF_MODE >> 2): clksrc_q <= wdata_q[1:0];
            default: ;
         endcase
      end
   end

   // Reset source flags: set wins over software clear
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         lvrst_flag_q <= 1'b0;
         lverr_flag_q <= 1'b0;
         wderr_flag_q <= 1'b0;
      end else begin
         if (lv_fire) begin
            lvrst_flag_q <= 1'b1; // R5
         end else if (flag_wr_lvrst) begin
            lvrst_flag_q <= 1'b0; // R12
         end
         if (lverr_fire) begin
            lverr_flag_q <= 1'b1; // R8
         end else if (flag_wr_lverr) begin
            lverr_flag_q <= 1'b0;
         end
         if (wderr_fire) begin
            wderr_flag_q <= 1'b1; // R17
         end else if (flag_wr_wderr) begin
            wderr_flag_q <= 1'b0; // R20
         end
      end
   end

   // Watchdog expiry and power-down flags
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         expiry_flag_q <= 1'b0; // R21
         pdown_flag_q <= 1'b0;
      end else if (state_q == MRSC_RUN) begin
         if (wdt_normal) begin
            expiry_flag_q <= 1'b1; // R13
         end else if (wdt_sleep) begin
            expiry_flag_q <= 1'b1; // R21
            pdown_flag_q <= 1'b1;
         end else if (sleep_mode) begin
            pdown_flag_q <= 1'b1;
         end
      end
   end

   // Read channel
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= 2'b00;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= 2'b00;
         case (s_axi_araddr[7:2])
            6'(`MRSC_OFF_LVSEL >> 2): s_axi_rdata <= {24'h00_0000, lvsel_q};
            6'(`MRSC_OFF_FLAGS >> 2): s_axi_rdata <= {29'h0000_0000, lvrst_flag_q,
                                                  lverr_flag_q, wderr_flag_q};
            6'(`MRSC_OFF_WDCTL >> 2): s_axi_rdata <= {24'h00_0000, wdctl_q};
            6'(`MRSC_OFF_STATUS >> 2): s_axi_rdata <= {30'h0000_0000, pdown_flag_q,
                                                   expiry_flag_q};
            6'(`MRSC_OFF_MODE >> 2): s_axi_rdata <= {30'h0000_0000, clksrc_q};
            default: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= 2'b10;
            end
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
   assign s_axi_arready = !s_axi_rvalid;
endmodule : mrsc_reset_ctrl
`default_nettype wire

// file: verification/mrsc_reset_ctrl_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module mrsc_reset_ctrl_chk #(
   parameter int POR_CYCLES = 50,
   parameter int WDT_CYCLES = 30
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic watchdog_timeout,
   input wire logic sleep_mode,
   input wire logic core_reset,
   input wire logic pc_clear,
   input wire logic port_preset,
   input wire logic [7:0] lv_threshold_sel,
   input wire logic [1:0] lv_level
);
   logic [15:0] up_q;
   logic [15:0] run_q;
   logic sel_ok;
   // Threshold holds an accepted code
   assign sel_ok = lv_threshold_sel inside {8'h55, 8'h33, 8'h99, 8'hAA};
   // Cycles since reset release
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         up_q <= 16'h0000;
      end else if (up_q != 16'hFFFF) begin
         up_q <= up_q + 16'h0001;
      end
   end
   // Length of the present reset hold
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         run_q <= 16'h0000;
      end else begin
         run_q <= core_reset ? run_q + 16'h0001 : 16'h0000;
      end
   end
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   preset_tracks_a: assert property (port_preset == core_reset)
      else $error("port preset differs from core reset");
   pc_with_reset_a: assert property (core_reset |-> pc_clear)
      else $error("core reset without pc clear");
   por_hold_a: assert property (up_q < POR_CYCLES - 1 |-> core_reset)
      else $error("power-on hold too short");
   level_decode_a: assert property (sel_ok |-> lv_level ==
      (lv_threshold_sel == 8'h33 ? 2'h1 : lv_threshold_sel == 8'h99 ? 2'h2 :
      lv_threshold_sel == 8'hAA ? 2'h3 : 2'h0))
      else $error("threshold level decode wrong");
   bad_sel_reset_a: assert property (!sel_ok |-> ##[1:40] core_reset)
      else $error("bad threshold code gave no reset");
   bad_sel_restore_a: assert property (!sel_ok |-> ##[1:40] lv_threshold_sel == 8'h55)
      else $error("bad threshold code not restored");
   wdt_normal_a: assert property (watchdog_timeout && !sleep_mode && !core_reset
      |-> ##[1:3] core_reset)
      else $error("normal expiry gave no reset");
   wdt_hold_a: assert property ($fell(core_reset) |-> run_q >= WDT_CYCLES - 2)
      else $error("reset hold too short");
   sleep_wake_a: assert property (watchdog_timeout && sleep_mode && !pc_clear
      |-> ##[1:3] (pc_clear && !core_reset))
      else $error("sleep expiry handled wrongly");
   // Main scenarios reached
   cover property ($rose(core_reset));
   cover property (watchdog_timeout && sleep_mode);
   cover property ($fell(pc_clear) && !core_reset);
endmodule : mrsc_reset_ctrl_chk
bind mrsc_reset_ctrl mrsc_reset_ctrl_chk #(.POR_CYCLES(POR_CYCLES), .WDT_CYCLES(WDT_CYCLES))
   u_chk (.*);
`default_nettype wire

// file: verification/tb.sv
`include "mrsc_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module tb;
   localparam int POR = 50;
   localparam int WDT = 30;
   localparam int DIV = 4;
   logic ref_clk = 1'b0, rst = 1'b1;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0000_0000;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic lowvolt_detect = 1'b0, watchdog_timeout = 1'b0;
   logic sleep_mode = 1'b0, powerdown_mode = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, lv_level;
   logic [31:0] s_axi_rdata;
   logic core_reset, pc_clear, port_preset, watchdog_enable;
   logic [2:0] wd_period_sel;
   logic [7:0] lv_threshold_sel;
   int miscompares = 0, samples_checked = 0, cycles = 0;
   mrsc_reset_ctrl #(.POR_CYCLES(POR), .WDT_CYCLES(WDT), .SLOW_DIV(DIV)) uut (.*);
   // Clock and hang guard
   always #50 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 5000) begin
         miscompares++;
         complete_run();
      end
   end
   task automatic complete_run;
      $display("checked %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : complete_run
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Bus write: address and data offered together, each dropped when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge ref_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : rd
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0] r;
      rd(a, d, r);
      chk(d, e);
   endtask : rdc
   // Count cycles until core reset or pc clear reaches a level
   task automatic wt(input bit pc, input logic v, output int n);
      n = 0;
      while ((pc ? pc_clear : core_reset) !== v && n < 2000) begin
         @(posedge ref_clk);
         n++;
      end
   endtask : wt
   task automatic pulse;
      @(posedge ref_clk);
      watchdog_timeout <= 1'b1;
      @(posedge ref_clk);
      watchdog_timeout <= 1'b0;
   endtask : pulse
   task automatic t_por;
      int n;
      logic [31:0] d;
      logic [1:0] r;
      chk(pc_clear, 1'b1);
      chk(port_preset, 1'b1);
      wt(0, 1'b0, n);
      chk(n >= POR - 1, 1'b1);
      rdc(`MRSC_OFF_LVSEL, 8'h55);
      rdc(`MRSC_OFF_WDCTL, 8'h53);
      rdc(`MRSC_OFF_STATUS, 8'h00);
      chk(watchdog_enable, 1'b1);
      chk(wd_period_sel, 3'h3);
      rd(8'h20, d, r);
      chk(r, 2'h2);
      wr(8'h20, 32'h0000_0000);
      chk(s_axi_bresp, 2'h2);
      wr(`MRSC_OFF_WDCTL, 32'h0000_0053);
      chk(s_axi_bresp, 2'h0);
   endtask : t_por
   task automatic t_dec;
      logic [7:0] c [4] = '{8'h55, 8'h33, 8'h99, 8'hAA};
      for (int i = 0; i < 4; i++) begin
         wr(`MRSC_OFF_LVSEL, c[i]);
         chk(lv_level, i[1:0]);
         chk(lv_threshold_sel, c[i]);
      end
   endtask : t_dec
   task automatic t_brn;
      int n;
      lowvolt_detect <= 1'b1;
      repeat (8) @(posedge ref_clk);
      lowvolt_detect <= 1'b0;
      repeat (30) @(posedge ref_clk);
      chk(core_reset, 1'b0);
      powerdown_mode <= 1'b1;
      lowvolt_detect <= 1'b1;
      repeat (40) @(posedge ref_clk);
      chk(core_reset, 1'b0);
      powerdown_mode <= 1'b0;
      wt(0, 1'b1, n);
      lowvolt_detect <= 1'b0;
      chk(n <= 30, 1'b1);
      wt(0, 1'b0, n);
      rdc(`MRSC_OFF_FLAGS, 8'h04);
      rdc(`MRSC_OFF_LVSEL, 8'hAA);
      wr(`MRSC_OFF_FLAGS, 8'hFF);
      rdc(`MRSC_OFF_FLAGS, 8'h04);
      wr(`MRSC_OFF_FLAGS, 8'h00);
      rdc(`MRSC_OFF_FLAGS, 8'h00);
   endtask : t_brn
   task automatic t_sel;
      int n;
      wr(`MRSC_OFF_LVSEL, 8'h12);
      wt(0, 1'b1, n);
      chk(n < 40, 1'b1);
      wt(0, 1'b0, n);
      rdc(`MRSC_OFF_LVSEL, 8'h55);
      rdc(`MRSC_OFF_FLAGS, 8'h02);
   endtask : t_sel
   task automatic t_key;
      int n;
      wr(`MRSC_OFF_WDCTL, 8'hAB);
      chk(watchdog_enable, 1'b0);
      wr(`MRSC_OFF_WDCTL, 8'h53);
      chk(watchdog_enable, 1'b1);
      wr(`MRSC_OFF_WDCTL, 8'h03);
      wt(0, 1'b1, n);
      chk(n >= DIV && n <= 3 * DIV + 1, 1'b1);
      wr(`MRSC_OFF_WDCTL, 8'h53);
      wt(0, 1'b0, n);
      rdc(`MRSC_OFF_FLAGS, 8'h03);
      wr(`MRSC_OFF_FLAGS, 8'h01);
      rdc(`MRSC_OFF_FLAGS, 8'h01);
      wr(`MRSC_OFF_FLAGS, 8'h00);
      rdc(`MRSC_OFF_FLAGS, 8'h00);
   endtask : t_key
   task automatic t_wdt;
      int n;
      int lo [3] = '{14, 1022, 1};
      int hi [3] = '{17, 1026, 2 * DIV + 2};
      pulse();
      wt(0, 1'b1, n);
      wt(0, 1'b0, n);
      chk(n >= WDT - 2, 1'b1);
      rdc(`MRSC_OFF_STATUS, 8'h01);
      for (int m = 0; m < 3; m++) begin
         wr(`MRSC_OFF_MODE, 32'(m));
         sleep_mode <= 1'b1;
         pulse();
         wt(1, 1'b1, n);
         wt(1, 1'b0, n);
         chk(n >= lo[m] && n <= hi[m], 1'b1);
         chk(core_reset, 1'b0);
         rdc(`MRSC_OFF_STATUS, 8'h03);
         sleep_mode <= 1'b0;
      end
   endtask : t_wdt
   // Main sequence
   initial begin
      repeat (12) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      t_por();
      t_dec();
      t_brn();
      t_sel();
      t_key();
      t_wdt();
      complete_run();
   end
endmodule : tb
`default_nettype wire
